//--- include/rsc_pkg.sv
// Constants, types and helper functions of the reset strap loader.
// Assumes a single 200 MHz clock domain and an APB register port.
package rsc_pkg;

  localparam int NGPIO = 16;
  localparam int GPIO_TWO_WIRE = 9;
  localparam int SEL_W = 4;
  localparam int NCFG = 16;
  localparam int CFG_W = 32;

  localparam logic [NGPIO-1:0] DEF_SEL_MASK = 16'h000F;
  localparam logic [NGPIO-1:0] DEF_CLK_EN = 16'h0000;
  localparam logic [NGPIO-1:0] DEF_GPIO_OE = 16'h0000;

  // Register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_SEL_MASK = 8'h04;
  localparam logic [7:0] A_EED_MASK = 8'h08;
  localparam logic [7:0] A_ADR_MASK = 8'h0C;
  localparam logic [7:0] A_CAPT = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_PORT_CFG = 8'h18;
  localparam logic [7:0] A_GPIO_OE = 8'h1C;
  localparam logic [1:0] MEM_WIN = 2'h1;

  // Stored configuration word layout
  localparam int CW_CLK_LSB = 0;
  localparam int CW_ADR_BIT = 16;
  localparam int CW_ADR_OVR = 17;
  localparam int CW_TW_BIT = 18;
  localparam int CW_CK_LSB = 24;

  // Status and port configuration field positions
  localparam int ST_STATE_LSB = 16;
  localparam int ST_CKERR_BIT = 20;
  localparam int ST_EEDIS_BIT = 21;
  localparam int ST_DONE_BIT = 22;
  localparam int PC_ADR_BIT = 16;
  localparam int PC_TW_BIT = 17;

  // Regulator settle time, least time rounded up
  localparam int CLK_PS = 5000;
  localparam int SETTLE_NS = 100;
  localparam int SETTLE_CYC = (SETTLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CNT_W = 8;

  typedef enum logic [2:0] {
    RSC_RESET = 3'h0,
    RSC_OTP_RD = 3'h1,
    RSC_OTP_CHK = 3'h2,
    RSC_EEPROM = 3'h3,
    RSC_PWR = 3'h4,
    RSC_PLL = 3'h5,
    RSC_DONE = 3'h6
  } rsc_state_t;

  typedef struct packed {
    logic [NGPIO-1:0] sel_word;
    logic eeprom_dis;
    logic addr_bit_two;
    logic two_wire;
  } rsc_strap_t;

  typedef struct packed {
    logic [NGPIO-1:0] clk_out_en;
    logic addr_bit_two;
    logic two_wire;
  } rsc_port_cfg_t;

  // Packs the masked pins, lowest index to LSB
  function automatic logic [NGPIO-1:0] rsc_pack(
    input logic [NGPIO-1:0] mask,
    input logic [NGPIO-1:0] pins
  );
    logic [NGPIO-1:0] r;
    int j;
    r = '0;
    j = 0;
    for (int i = 0; i < NGPIO; i++) begin
      if (mask[i]) begin
        r[j[3:0]] = pins[i];
        j = j + 1;
      end
    end
    return r;
  endfunction

  // Value of the highest-indexed masked pin, zero if none
  function automatic logic rsc_hi_pick(
    input logic [NGPIO-1:0] mask,
    input logic [NGPIO-1:0] pins
  );
    logic r;
    r = 1'b0;
    for (int i = 0; i < NGPIO; i++) begin
      if (mask[i]) begin
        r = pins[i];
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] rsc_cksum(input logic [CFG_W-1:0] w);
    return w[7:0] ^ w[15:8] ^ w[23:16];
  endfunction

endpackage

//--- src/rsc_cfg_mem.sv
// Store of up to sixteen configuration words with a registered read port.
// Assumes writes come from the register port before master reset release.
`timescale 1ns/1ps
module rsc_cfg_mem import rsc_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire logic we,
  input wire logic [SEL_W-1:0] waddr,
  input wire logic [CFG_W-1:0] wdata,
  input wire logic re,
  input wire logic [SEL_W-1:0] raddr,
  output logic [CFG_W-1:0] rdata
);

  logic [CFG_W-1:0] mem [NCFG];

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule

//--- src/rsc_strap_loader.sv
// Reset strap capture and initial configuration sequencer.
// Assumes pins and the PLL lock arrive asynchronously; APB runs on mclk.
`timescale 1ns/1ps
module rsc_strap_loader import rsc_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire logic master_reset_n,
  input wire logic [NGPIO-1:0] gpio_pin,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic eeprom_done,
  input wire logic pll_lock,
  output logic eeprom_start,
  output logic reg_en,
  output logic clk_int_en,
  output logic pll_cal_start,
  output logic load_done,
  output logic [NGPIO-1:0] gpio_oe,
  output rsc_port_cfg_t port_cfg
);

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic mr_s1, mr_s2, mr_s3, mr_stable, mr_rise;
  logic lk_s1, lk_s2, lk_s3, lock_stable;
  logic [NGPIO-1:0] g_s1, g_s2, g_s3, gpio_stable, g_eq;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mr_s1 <= 1'b0;
      mr_s2 <= 1'b0;
      mr_s3 <= 1'b0;
      mr_stable <= 1'b0;
      lk_s1 <= 1'b0;
      lk_s2 <= 1'b0;
      lk_s3 <= 1'b0;
      lock_stable <= 1'b0;
      g_s1 <= '0;
      g_s2 <= '0;
      g_s3 <= '0;
      gpio_stable <= '0;
    end else begin
      mr_s1 <= master_reset_n;
      mr_s2 <= mr_s1;
      mr_s3 <= mr_s2;
      if (mr_s2 == mr_s3) begin
        mr_stable <= mr_s3;
      end
      lk_s1 <= pll_lock;
      lk_s2 <= lk_s1;
      lk_s3 <= lk_s2;
      if (lk_s2 == lk_s3) begin
        lock_stable <= lk_s3;
      end
      g_s1 <= gpio_pin;
      g_s2 <= g_s1;
      g_s3 <= g_s2;
      gpio_stable <= (g_s3 & g_eq) | (gpio_stable & ~g_eq);
    end
  end

  assign mr_rise = (mr_s2 == mr_s3) && mr_s3 && !mr_stable;
  assign g_eq = ~(g_s2 ^ g_s3);

  ////////////////////////////////////////////////////////////////////////
  // Factory pin assignment and strap capture

  logic programmed;
  logic [NGPIO-1:0] sel_mask, eed_mask, adr_mask;
  logic [NGPIO-1:0] eff_sel, eff_eed, eff_adr, use_sel;
  logic [NGPIO-1:0] cap_pins;
  rsc_strap_t strap;
  rsc_strap_t next_strap;

  // Unprogrammed parts keep default pin behaviour
  assign eff_sel = programmed ? sel_mask : '0;
  assign eff_eed = programmed ? eed_mask : '0;
  assign eff_adr = programmed ? adr_mask : '0;
  assign use_sel = (eff_sel == '0) ? DEF_SEL_MASK : eff_sel;

  always_comb begin
    next_strap.sel_word = rsc_pack(use_sel, gpio_stable);
    next_strap.eeprom_dis = |(eff_eed & gpio_stable);
    next_strap.addr_bit_two = rsc_hi_pick(eff_adr, gpio_stable);
    next_strap.two_wire = gpio_stable[GPIO_TWO_WIRE];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      strap <= '0;
      cap_pins <= '0;
    end else if (mr_rise) begin
      strap <= next_strap;
      cap_pins <= gpio_stable;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  rsc_state_t state;
  logic [CNT_W-1:0] cnt;
  logic [CFG_W-1:0] mem_rdata;
  logic sel_ok, ck_ok, cksum_err;

  // Only sixteen sets exist; a wider word beyond them loads nothing
  assign sel_ok = programmed && (strap.sel_word[NGPIO-1:SEL_W] == '0);
  assign ck_ok = rsc_cksum(mem_rdata) == mem_rdata[CW_CK_LSB +: 8];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= RSC_RESET;
      cnt <= '0;
      eeprom_start <= 1'b0;
      pll_cal_start <= 1'b0;
      cksum_err <= 1'b0;
    end else if (!mr_stable && !mr_rise) begin
      state <= RSC_RESET;
      cnt <= '0;
      eeprom_start <= 1'b0;
      pll_cal_start <= 1'b0;
      cksum_err <= 1'b0;
    end else begin
      eeprom_start <= 1'b0;
      pll_cal_start <= 1'b0;
      case (state)
        RSC_RESET: begin
          if (mr_rise) begin
            state <= RSC_OTP_RD;
          end
        end
        RSC_OTP_RD: begin
          state <= sel_ok ? RSC_OTP_CHK : RSC_EEPROM;
          eeprom_start <= !sel_ok && !strap.eeprom_dis;
        end
        RSC_OTP_CHK: begin
          cksum_err <= !ck_ok;
          state <= RSC_EEPROM;
          eeprom_start <= !strap.eeprom_dis;
        end
        RSC_EEPROM: begin
          if (strap.eeprom_dis || eeprom_done) begin
            state <= RSC_PWR;
            cnt <= '0;
          end
        end
        RSC_PWR: begin
          if (cnt == CNT_W'(SETTLE_CYC - 1)) begin
            state <= RSC_PLL;
            pll_cal_start <= 1'b1;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        RSC_PLL: begin
          if (lock_stable) begin
            state <= RSC_DONE;
          end
        end
        RSC_DONE: state <= RSC_DONE;
        default: state <= RSC_RESET;
      endcase
    end
  end

  assign reg_en = (state == RSC_PWR) || (state == RSC_PLL) ||
                  (state == RSC_DONE);
  assign clk_int_en = (state == RSC_PLL) || (state == RSC_DONE);
  assign load_done = (state == RSC_DONE);

  ////////////////////////////////////////////////////////////////////////
  // Register port

  logic acc, wr_en;
  logic [31:0] next_prdata;

  function automatic logic addr_hit(input logic [7:0] a);
    logic r;
    case (a)
      A_CTRL, A_SEL_MASK, A_EED_MASK, A_ADR_MASK, A_CAPT, A_STATUS,
      A_PORT_CFG, A_GPIO_OE: r = 1'b1;
      default: r = (a[7:6] == MEM_WIN) && (a[1:0] == 2'h0);
    endcase
    return r;
  endfunction

  assign acc = psel && penable;
  assign pready = 1'b1;
  assign pslverr = acc && !addr_hit(paddr);
  assign wr_en = acc && pwrite && addr_hit(paddr);

  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      A_CTRL: next_prdata[0] = programmed;
      A_SEL_MASK: next_prdata[NGPIO-1:0] = sel_mask;
      A_EED_MASK: next_prdata[NGPIO-1:0] = eed_mask;
      A_ADR_MASK: next_prdata[NGPIO-1:0] = adr_mask;
      A_CAPT: next_prdata[NGPIO-1:0] = cap_pins;
      A_STATUS: begin
        next_prdata[NGPIO-1:0] = strap.sel_word;
        next_prdata[ST_STATE_LSB +: 3] = state;
        next_prdata[ST_CKERR_BIT] = cksum_err;
        next_prdata[ST_EEDIS_BIT] = strap.eeprom_dis;
        next_prdata[ST_DONE_BIT] = load_done;
      end
      A_PORT_CFG: begin
        next_prdata[NGPIO-1:0] = port_cfg.clk_out_en;
        next_prdata[PC_ADR_BIT] = port_cfg.addr_bit_two;
        next_prdata[PC_TW_BIT] = port_cfg.two_wire;
      end
      A_GPIO_OE: next_prdata[NGPIO-1:0] = gpio_oe;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // Read data captured in the setup phase, shown in the access phase
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      programmed <= 1'b0;
      sel_mask <= '0;
      eed_mask <= '0;
      adr_mask <= '0;
    end else if (wr_en) begin
      case (paddr)
        A_CTRL: programmed <= pwdata[0];
        A_SEL_MASK: sel_mask <= pwdata[NGPIO-1:0];
        A_EED_MASK: eed_mask <= pwdata[NGPIO-1:0];
        A_ADR_MASK: adr_mask <= pwdata[NGPIO-1:0];
        default: programmed <= programmed;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port configuration and pin direction

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      port_cfg.clk_out_en <= DEF_CLK_EN;
      port_cfg.addr_bit_two <= 1'b0;
      port_cfg.two_wire <= 1'b0;
    end else if (!mr_stable && !mr_rise) begin
      port_cfg.clk_out_en <= DEF_CLK_EN;
      port_cfg.addr_bit_two <= 1'b0;
      port_cfg.two_wire <= 1'b0;
    end else if (mr_rise) begin
      port_cfg.two_wire <= next_strap.two_wire;
      port_cfg.addr_bit_two <= next_strap.two_wire &&
                               next_strap.addr_bit_two;
    end else if (state == RSC_OTP_CHK && ck_ok) begin
      port_cfg.clk_out_en <= mem_rdata[CW_CLK_LSB +: NGPIO];
      if (mem_rdata[CW_ADR_OVR]) begin
        port_cfg.addr_bit_two <= mem_rdata[CW_ADR_BIT];
        port_cfg.two_wire <= mem_rdata[CW_TW_BIT];
      end
    end else if (wr_en && paddr == A_PORT_CFG) begin
      port_cfg.clk_out_en <= pwdata[NGPIO-1:0];
      port_cfg.addr_bit_two <= pwdata[PC_ADR_BIT];
      port_cfg.two_wire <= pwdata[PC_TW_BIT];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gpio_oe <= DEF_GPIO_OE;
    end else if (!mr_stable) begin
      gpio_oe <= DEF_GPIO_OE;
    end else if (wr_en && paddr == A_GPIO_OE) begin
      gpio_oe <= pwdata[NGPIO-1:0];
    end
  end

  rsc_cfg_mem u_mem (
    .mclk(mclk),
    .rst(rst),
    .we(wr_en && paddr[7:6] == MEM_WIN),
    .waddr(paddr[5:2]),
    .wdata(pwdata),
    .re(state == RSC_OTP_RD),
    .raddr(strap.sel_word[SEL_W-1:0]),
    .rdata(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks

  a_capture_hold: assert property (
    !mr_rise |=> $stable(cap_pins) && $stable(strap)
  ) else $error("captured straps changed without reset release");
  a_default_sel: assert property (
    mr_rise && eff_sel == '0 |=>
      strap.sel_word == {12'h000, $past(gpio_stable[3:0])}
  ) else $error("default selection pins not used");
  a_eedis_skip: assert property (
    state == RSC_EEPROM && strap.eeprom_dis |=> state == RSC_PWR
  ) else $error("disabled EEPROM search not skipped");
  a_eeprom_try: assert property (
    state == RSC_OTP_CHK && !strap.eeprom_dis |=>
      eeprom_start && state == RSC_EEPROM
  ) else $error("EEPROM search not started");
  a_adr_zero: assert property (
    mr_rise && eff_adr == '0 |=> !port_cfg.addr_bit_two
  ) else $error("address bit two not zero by default");
  a_unprog_noload: assert property (
    state == RSC_OTP_CHK |-> programmed
  ) else $error("stored set loaded on unprogrammed part");
  a_cksum_skip: assert property (
    state == RSC_OTP_CHK && !ck_ok && !wr_en |=>
      port_cfg == $past(port_cfg) && cksum_err
  ) else $error("bad stored set was applied");
  a_reset_defaults: assert property (
    !mr_stable && !mr_rise |=>
      port_cfg.clk_out_en == DEF_CLK_EN && gpio_oe == DEF_GPIO_OE
  ) else $error("defaults not applied in master reset");
  a_pll_order: assert property (
    $rose(pll_cal_start) |-> reg_en && clk_int_en && $past(reg_en) &&
      !$past(clk_int_en)
  ) else $error("PLL calibration out of order");
  a_bus_write: assert property (
    wr_en && paddr == A_PORT_CFG && mr_stable && !mr_rise &&
      state != RSC_OTP_CHK |=> port_cfg.clk_out_en == $past(pwdata[15:0])
  ) else $error("port configuration not writable");

endmodule

//--- dv/rsc_board_model.sv
// Board model: strap pins with pull-ups, master reset, EEPROM engine and PLL.
// Assumes the bench calls boot() to run one master reset cycle.
`timescale 1ns/1ps
module rsc_board_model import rsc_pkg::*; (
  input wire logic mclk,
  output logic master_reset_n,
  output logic [NGPIO-1:0] gpio_pin,
  input wire logic eeprom_start,
  output logic eeprom_done,
  input wire logic pll_cal_start,
  output logic pll_lock
);
  logic [NGPIO-1:0] drv_val = '0;
  logic [NGPIO-1:0] drv_en = '0;
  int ee_cnt = -1;
  int pl_cnt = -1;
  int dly = 1;

  initial begin
    master_reset_n = 1'b1;
    eeprom_done = 1'b0;
    pll_lock = 1'b0;
  end

  // Released pins go to the pull-up level
  assign gpio_pin = (drv_val & drv_en) | ~drv_en;

  ////////////////////////////////////////////////////////////////////////
  // Slow or prompt answers to the start pulses
  always @(posedge mclk) begin
    eeprom_done <= 1'b0;
    if (eeprom_start === 1'b1) begin
      ee_cnt <= dly;
    end else if (ee_cnt > 0) begin
      ee_cnt <= ee_cnt - 1;
    end else if (ee_cnt == 0) begin
      eeprom_done <= 1'b1;
      ee_cnt <= -1;
    end
    if (master_reset_n == 1'b0) begin
      pll_lock <= 1'b0;
    end else if (pll_cal_start === 1'b1) begin
      pl_cnt <= dly;
    end else if (pl_cnt > 0) begin
      pl_cnt <= pl_cnt - 1;
    end else if (pl_cnt == 0) begin
      pll_lock <= 1'b1;
      pl_cnt <= -1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Straps held across the reset release, then let go
  task automatic boot(input logic [15:0] v, input logic [15:0] en,
                      input int d);
    @(posedge mclk);
    master_reset_n <= 1'b0;
    drv_val <= v;
    drv_en <= en;
    dly <= d;
    repeat (8) @(posedge mclk);
    master_reset_n <= 1'b1;
    repeat (8) @(posedge mclk);
    drv_en <= '0;
  endtask
endmodule

//--- dv/tb_top.sv
// Self-checking bench of the reset strap loader with a behavioural model.
// Assumes the board model answers EEPROM and PLL requests.
`timescale 1ns/1ps
module tb_top import rsc_pkg::*;;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rq;
  logic pready, pslverr, rerr, master_reset_n, eeprom_done, pll_lock;
  logic eeprom_start, reg_en, clk_int_en, pll_cal_start, load_done;
  logic [NGPIO-1:0] gpio_pin, gpio_oe;
  rsc_port_cfg_t port_cfg;
  int seed = 10, miscompares = 0, num_checks = 0, cyc = 0;
  int ee_cnt = 0, cal_cnt = 0, tno = 0;

  rsc_strap_loader dut_u (.mclk(mclk), .rst(rst),
    .master_reset_n(master_reset_n), .gpio_pin(gpio_pin), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .eeprom_done(eeprom_done), .pll_lock(pll_lock),
    .eeprom_start(eeprom_start), .reg_en(reg_en), .clk_int_en(clk_int_en),
    .pll_cal_start(pll_cal_start), .load_done(load_done),
    .gpio_oe(gpio_oe), .port_cfg(port_cfg));

  rsc_board_model board_u (.mclk(mclk), .master_reset_n(master_reset_n),
    .gpio_pin(gpio_pin), .eeprom_start(eeprom_start),
    .eeprom_done(eeprom_done), .pll_cal_start(pll_cal_start),
    .pll_lock(pll_lock));

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    ee_cnt += (eeprom_start === 1'b1);
    cal_cnt += (pll_cal_start === 1'b1);
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rq = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // One master reset cycle against the model
  task automatic run_case(input logic prog, input logic [15:0] sm, em, am,
                          v, en, input logic good);
    logic [15:0] pins, m, sel, clk;
    logic [31:0] w;
    logic eed, adr, tw, ld, ck;
    int j, n;
    pins = (v & en) | ~en;
    m = (prog && sm != 0) ? sm : 16'h000F;
    sel = '0;
    j = 0;
    eed = 1'b0;
    adr = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (m[i]) begin
        sel[j] = pins[i];
        j++;
      end
      if (prog && em[i] && pins[i]) eed = 1'b1;
      if (prog && am[i]) adr = pins[i];
    end
    tw = pins[9];
    adr = adr & tw;
    w = $random(seed);
    w[31:24] = w[7:0] ^ w[15:8] ^ w[23:16] ^ {7'h0, !good};
    ld = prog && sel < 16 && good;
    ck = prog && sel < 16 && !good;
    apb(1'b1, A_CTRL, {31'h0, prog});
    apb(1'b1, A_SEL_MASK, {16'h0, sm});
    apb(1'b1, A_EED_MASK, {16'h0, em});
    apb(1'b1, A_ADR_MASK, {16'h0, am});
    if (sel < 16) apb(1'b1, 8'h40 + {2'b00, sel[3:0], 2'b00}, w);
    ee_cnt = 0;
    cal_cnt = 0;
    board_u.boot(v, en, {$random(seed)} % 24);
    n = 0;
    while (load_done !== 1'b1 && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    clk = ld ? w[15:0] : 16'h0;
    if (ld && w[17]) begin
      adr = w[16];
      tw = w[18];
    end
    chk("done", {31'h0, load_done}, 32'h1);
    chk("port_cfg", {14'h0, port_cfg}, {14'h0, clk, adr, tw});
    apb(1'b0, A_PORT_CFG, '0);
    chk("port_reg", rq, {14'h0, tw, adr, clk});
    apb(1'b0, A_CAPT, '0);
    chk("captured", rq, {16'h0, pins});
    apb(1'b0, A_STATUS, '0);
    chk("status", rq, {9'h0, 1'b1, eed, ck, 1'b0, RSC_DONE, sel});
    chk("ee_start", ee_cnt, {31'h0, !eed});
    chk("power", {29'h0, reg_en, clk_int_en, cal_cnt == 1}, 32'h7);
    chk("gpio_oe", {16'h0, gpio_oe}, {16'h0, DEF_GPIO_OE});
    tno++;
    $display("test %0d done", tno);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] sm, em, am;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    while (load_done !== 1'b1) begin
      @(posedge mclk);
    end
    run_case(1'b0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 1'b1);
    run_case(1'b1, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 1'b1);
    run_case(1'b1, 16'h0164, 16'h0, 16'h0, 16'h0124, 16'hFFFF, 1'b1);
    run_case(1'b1, 16'h1002, 16'h0C00, 16'h00A0, 16'h0A80, 16'hFFFF,
             1'b1);
    run_case(1'b1, 16'h1002, 16'h0C00, 16'h00A0, 16'h0480, 16'hFFFF,
             1'b1);
    run_case(1'b1, 16'h003F, 16'h0, 16'h0, 16'h0010, 16'hFFFF, 1'b1);
    run_case(1'b1, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 1'b0);
    for (int k = 0; k < 8; k++) begin
      sm = 16'($random(seed)) & 16'($random(seed)) & 16'hFDFF;
      em = 16'($random(seed)) & ~sm & 16'hFDFF;
      am = 16'($random(seed)) & ~sm & ~em & 16'hFDFF;
      run_case(1'b1, sm, em, am, 16'($random(seed)), 16'($random(seed)),
               1'($random(seed)));
    end
    apb(1'b1, A_PORT_CFG, 32'h0002_A5C3);
    apb(1'b0, A_PORT_CFG, '0);
    chk("port_wr", rq, 32'h0002_A5C3);
    chk("port_out", {14'h0, port_cfg}, {14'h0, 16'hA5C3, 2'b01});
    apb(1'b1, A_GPIO_OE, 32'h0000_00F0);
    apb(1'b0, 8'h80, '0);
    chk("unmapped", {31'h0, rerr}, 32'h1);
    chk("gpio_oe_wr", {16'h0, gpio_oe}, 32'h0000_00F0);
    $display("test register access done");
    end_sim();
  end
endmodule
